// [hdl/tmr_pkg.sv]
// Types shared by the timer core and its tick generator.
// Assumes nothing outside this package.
package tmr_pkg;

   // ----------------------------------------
   // Waveform modes and compare output actions
   // ----------------------------------------
   typedef enum logic [1:0] {
      TMR_WAVE_NORMAL = 2'b00,
      TMR_WAVE_PHASE = 2'b01,
      TMR_WAVE_CTC = 2'b10,
      TMR_WAVE_FAST = 2'b11
   } tmr_wave_t;

   typedef enum logic [1:0] {
      TMR_ACT_NONE = 2'b00,
      TMR_ACT_TOGGLE = 2'b01,
      TMR_ACT_CLEAR = 2'b10,
      TMR_ACT_SET = 2'b11
   } tmr_act_t;

   // Both PWM modes share buffering and forbid forcing
   function automatic logic tmr_is_pwm(input tmr_wave_t w);
      return (w == TMR_WAVE_PHASE) || (w == TMR_WAVE_FAST);
   endfunction

endpackage

// [hdl/tmr_regs.svh]
// Register map and constants of the 8-bit timer/counter.
// Assumes an AXI4-Lite slave with 32-bit data; registers sit in the low byte.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define TMR_OFS_CTRL 5'h00
`define TMR_OFS_COUNT 5'h04
`define TMR_OFS_COMPARE 5'h08
`define TMR_OFS_FLAG 5'h0c
`define TMR_OFS_MASK 5'h10
`define TMR_OFS_ASYNC 5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TMR_CTRL_CS_LSB 0
`define TMR_CTRL_WAVE_LSB 3
`define TMR_CTRL_ACT_LSB 5
`define TMR_CTRL_FORCE_BIT 7
`define TMR_FLAG_OVF_BIT 0
`define TMR_FLAG_CMP_BIT 1
`define TMR_ASYNC_SEL_BIT 0
`define TMR_ASYNC_EXT_BIT 1
`define TMR_ASYNC_RISE_BIT 2

// ----------------------------------------
// Reset values and counter extremes
// ----------------------------------------
`define TMR_RST_BYTE 8'h00
`define TMR_BOTTOM 8'h00
`define TMR_MAX 8'hff

// ----------------------------------------
// Prescaler tap masks (divide by 1, 8, 32, 64, 128, 256, 1024)
// ----------------------------------------
`define TMR_DIV1_MASK 10'h000
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV32_MASK 10'h01f
`define TMR_DIV64_MASK 10'h03f
`define TMR_DIV128_MASK 10'h07f
`define TMR_DIV256_MASK 10'h0ff
`define TMR_DIV1024_MASK 10'h3ff

`endif

// [hdl/tmr_tick_gen.sv]
// Timer tick generator: pin synchronisers, prescaler and source select.
// Assumes the pins are asynchronous to aclk and toggle slower than aclk/2.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_tick_gen
   import tmr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_count_pin,
   input wire logic crystal_pin_a,
   tmr_tick_if.gen tick_if
);
   logic [1:0] ext_sync;
   logic ext_last;
   logic [1:0] xtal_sync;
   logic xtal_last;
   logic [9:0] presc;
   logic tick;

   // Tap mask for the selected division
   function automatic logic [9:0] presc_mask(input logic [2:0] cs);
      logic [9:0] m;
      m = `TMR_DIV1_MASK;
      unique case (cs)
         3'h2: m = `TMR_DIV8_MASK;
         3'h3: m = `TMR_DIV32_MASK;
         3'h4: m = `TMR_DIV64_MASK;
         3'h5: m = `TMR_DIV128_MASK;
         3'h6: m = `TMR_DIV256_MASK;
         3'h7: m = `TMR_DIV1024_MASK;
         default: m = `TMR_DIV1_MASK;
      endcase
      return m;
   endfunction

   // ----------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------
   wire ext_rise_evt = ext_sync[1] & ~ext_last;
   wire ext_fall_evt = ~ext_sync[1] & ext_last;
   wire xtal_pulse = xtal_sync[1] & ~xtal_last;
   // Crystal edges replace the bus clock as prescaler source
   wire src_pulse = tick_if.async_sel ? xtal_pulse : 1'b1;
   wire [9:0] tap_mask = presc_mask(tick_if.clock_sel);
   wire presc_hit = src_pulse && ((presc & tap_mask) == tap_mask);
   wire ext_hit = tick_if.ext_rise ? ext_rise_evt : ext_fall_evt;
   wire next_tick = (tick_if.clock_sel != 3'h0) && (tick_if.ext_sel ? ext_hit : presc_hit);

   // Two flops before any edge logic reads a pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 2'h0;
         ext_last <= 1'b0;
         xtal_sync <= 2'h0;
         xtal_last <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[0], ext_count_pin};
         ext_last <= ext_sync[1];
         xtal_sync <= {xtal_sync[0], crystal_pin_a};
         xtal_last <= xtal_sync[1];
      end
   end

   // Free-running prescaler; shared taps keep the divisions phase aligned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc <= 10'h000;
         tick <= 1'b0;
      end else begin
         presc <= src_pulse ? 10'(presc + 10'h001) : presc;
         tick <= next_tick;
      end
   end

   assign tick_if.tick = tick;
endmodule
`default_nettype wire

// [hdl/tmr_tick_if.sv]
// Tick source selection and the resulting timer tick.
// Assumes both ends run on aclk.
`timescale 1ns/100ps
`default_nettype none
interface tmr_tick_if;
   logic [2:0] clock_sel;
   logic async_sel;
   logic ext_sel;
   logic ext_rise;
   logic tick;

   modport gen (input clock_sel, input async_sel, input ext_sel, input ext_rise, output tick);
   modport core (output clock_sel, output async_sel, output ext_sel, output ext_rise, input tick);
endinterface
`default_nettype wire

// [hdl/tmr_timer8.sv]
// Single-channel 8-bit timer/counter with compare output and AXI4-Lite registers.
// Assumes one clock; the interrupt controller pulses the ack inputs on service.
// Behaviour
// - Count and compare are 8-bit read/write registers
// - Tick from prescaler or pin; zero stops
// - Async select takes tick from crystal
// - Bottom is 0x00, max 0xFF, top per mode
// - Each tick clears, increments or decrements counter
// - Counter write beats count; always accessible
// - Waveform field picks sequence and overflow timing
// - Match sets compare flag on next tick
// - Enabled compare flag raises interrupt request
// - Flag clears on service or written one
// - PWM modes buffer compare; others bypass
// - Buffered mode: software sees buffer register
// - Force strobe acts like match, no flag
// - Counter write blocks match at next tick
// - Output from match, max, bottom, mode, action
// - Output state kept across mode changes
// - Action field takes effect immediately
// - Both flags readable, individually maskable
// - Modes: normal 0, phase 1, CTC 2, fast 3
// - Action zero never changes output
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_timer8
   import tmr_pkg::*;
#(
   parameter int AW = 5
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_count_pin,
   input wire logic crystal_pin_a,
   input wire logic ovf_irq_ack,
   input wire logic cmp_irq_ack,
   output logic ovf_irq,
   output logic cmp_irq,
   output logic compare_output,
   output logic compare_output_en
);
   if (AW < 5 || AW > 32) begin : g_bad_aw
      $error("tmr_timer8: AW must lie in 5..32");
   end

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic aw_held;
   logic [AW-1:0] aw_addr;
   logic w_held;
   logic [7:0] w_byte;
   logic w_lane0;
   logic [2:0] ctrl_cs;
   tmr_wave_t wave;
   tmr_act_t act;
   logic async_sel;
   logic ext_sel;
   logic ext_rise;
   logic mask_ovf;
   logic mask_cmp;
   logic flag_ovf;
   logic flag_cmp;
   logic [7:0] count;
   logic [7:0] ocr_act;
   logic [7:0] ocr_buf;
   logic down;
   logic block;
   logic oc;

   tmr_tick_if tif ();

   tmr_tick_gen u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_count_pin(ext_count_pin),
      .crystal_pin_a(crystal_pin_a),
      .tick_if(tif)
   );

   assign tif.clock_sel = ctrl_cs;
   assign tif.async_sel = async_sel;
   assign tif.ext_sel = ext_sel;
   assign tif.ext_rise = ext_rise;

   // Address hit: upper bits zero, low bits equal the word offset
   function automatic logic addr_hit(input logic [AW-1:0] a, input logic [4:0] ofs);
      return ((a >> 5) == '0) && ({a[4:2], 2'b00} == ofs);
   endfunction

   // Output action applied on a match or a force
   function automatic logic act_apply(input tmr_act_t a, input logic o);
      logic r;
      r = o;
      unique case (a)
         TMR_ACT_NONE: r = o;
         TMR_ACT_TOGGLE: r = ~o;
         TMR_ACT_CLEAR: r = 1'b0;
         TMR_ACT_SET: r = 1'b1;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   wire do_wr = aw_held && w_held && !s_axi_bvalid;
   wire wr_ok = addr_hit(aw_addr, `TMR_OFS_CTRL) || addr_hit(aw_addr, `TMR_OFS_COUNT)
      || addr_hit(aw_addr, `TMR_OFS_COMPARE) || addr_hit(aw_addr, `TMR_OFS_FLAG)
      || addr_hit(aw_addr, `TMR_OFS_MASK) || addr_hit(aw_addr, `TMR_OFS_ASYNC);
   // Only byte lane 0 carries register bits
   wire wr_go = do_wr && w_lane0;
   wire we_ctrl = wr_go && addr_hit(aw_addr, `TMR_OFS_CTRL);
   wire we_count = wr_go && addr_hit(aw_addr, `TMR_OFS_COUNT);
   wire we_cmp = wr_go && addr_hit(aw_addr, `TMR_OFS_COMPARE);
   wire we_flag = wr_go && addr_hit(aw_addr, `TMR_OFS_FLAG);
   wire we_mask = wr_go && addr_hit(aw_addr, `TMR_OFS_MASK);
   wire we_async = wr_go && addr_hit(aw_addr, `TMR_OFS_ASYNC);
   wire rd_go = s_axi_arvalid && s_axi_arready;

   // ----------------------------------------
   // Counter unit
   // ----------------------------------------
   wire pwm = tmr_is_pwm(wave);
   wire at_max = (count == `TMR_MAX);
   wire at_bottom = (count == `TMR_BOTTOM);
   wire match_eff = (count == ocr_act) && !block;
   // Write wins over every tick-driven change except the direction update
   wire tick_run = tif.tick && !we_count;
   wire match_evt = tick_run && match_eff;
   wire next_down = (wave == TMR_WAVE_PHASE) && (at_max ? 1'b1 : (at_bottom ? 1'b0 : down));
   wire ctc_clear = (wave == TMR_WAVE_CTC) && match_eff;
   wire [7:0] next_step = next_down ? 8'(count - 8'h01) : 8'(count + 8'h01);
   wire [7:0] next_count = we_count ? w_byte : (!tif.tick ? count : (ctc_clear ? `TMR_BOTTOM : next_step));
   // Phase correct flags at bottom; the others at the max-to-bottom step
   wire ovf_evt = tick_run && ((wave == TMR_WAVE_PHASE) ? at_bottom : at_max);
   // Max is top for the phase mode and the step to bottom for fast PWM
   wire buf_upd = pwm && tick_run && at_max;

   // ----------------------------------------
   // Waveform generator
   // ----------------------------------------
   wire [7:0] ctrl_wr_byte = w_byte;
   wire force_evt = we_ctrl && ctrl_wr_byte[`TMR_CTRL_FORCE_BIT]
      && !tmr_is_pwm(tmr_wave_t'(ctrl_wr_byte[`TMR_CTRL_WAVE_LSB +: 2]));
   wire [1:0] act_code = act;
   wire pwm_act = act_code[1];
   wire fast_bot = (wave == TMR_WAVE_FAST) && tick_run && at_max;
   // Fast PWM: match drives one level, bottom the other, bottom wins
   wire fast_oc = fast_bot ? (act == TMR_ACT_CLEAR) : (match_evt ? (act == TMR_ACT_SET) : oc);
   // Phase correct: level depends on counting direction at the match
   wire phase_oc = match_evt ? ((act == TMR_ACT_SET) ^ down) : oc;
   wire pwm_oc = !pwm_act ? oc : ((wave == TMR_WAVE_FAST) ? fast_oc : phase_oc);
   wire plain_oc = match_evt ? act_apply(act, oc) : oc;
   wire next_oc = force_evt ? act_apply(tmr_act_t'(ctrl_wr_byte[`TMR_CTRL_ACT_LSB +: 2]), oc)
      : (pwm ? pwm_oc : plain_oc);

   // ----------------------------------------
   // Flags: a set in the clearing cycle wins
   // ----------------------------------------
   wire clr_ovf = (we_flag && w_byte[`TMR_FLAG_OVF_BIT]) || ovf_irq_ack;
   wire clr_cmp = (we_flag && w_byte[`TMR_FLAG_CMP_BIT]) || cmp_irq_ack;
   wire next_flag_ovf = ovf_evt || (flag_ovf && !clr_ovf);
   wire next_flag_cmp = match_evt || (flag_cmp && !clr_cmp);

   assign ovf_irq = flag_ovf && mask_ovf;
   assign cmp_irq = flag_cmp && mask_cmp;
   assign compare_output = oc;
   assign compare_output_en = (act != TMR_ACT_NONE);

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire [7:0] ctrl_rd = {1'b0, act_code, wave, ctrl_cs};
   wire [7:0] cmp_rd = pwm ? ocr_buf : ocr_act;
   wire [7:0] rd_byte = addr_hit(s_axi_araddr, `TMR_OFS_CTRL) ? ctrl_rd
      : addr_hit(s_axi_araddr, `TMR_OFS_COUNT) ? count
      : addr_hit(s_axi_araddr, `TMR_OFS_COMPARE) ? cmp_rd
      : addr_hit(s_axi_araddr, `TMR_OFS_FLAG) ? {6'h00, flag_cmp, flag_ovf}
      : addr_hit(s_axi_araddr, `TMR_OFS_MASK) ? {6'h00, mask_cmp, mask_ovf}
      : addr_hit(s_axi_araddr, `TMR_OFS_ASYNC) ? {5'h00, ext_rise, ext_sel, async_sel}
      : `TMR_RST_BYTE;
   wire rd_ok = addr_hit(s_axi_araddr, `TMR_OFS_CTRL) || addr_hit(s_axi_araddr, `TMR_OFS_COUNT)
      || addr_hit(s_axi_araddr, `TMR_OFS_COMPARE) || addr_hit(s_axi_araddr, `TMR_OFS_FLAG)
      || addr_hit(s_axi_araddr, `TMR_OFS_MASK) || addr_hit(s_axi_araddr, `TMR_OFS_ASYNC);

   // Write channel capture; address and data may come in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_byte <= `TMR_RST_BYTE;
         w_lane0 <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (do_wr) begin
            w_held <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel; reads have no side effects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Configuration registers; action field acts at once, unbuffered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_cs <= 3'h0;
         wave <= TMR_WAVE_NORMAL;
         act <= TMR_ACT_NONE;
         async_sel <= 1'b0;
         ext_sel <= 1'b0;
         ext_rise <= 1'b0;
         mask_ovf <= 1'b0;
         mask_cmp <= 1'b0;
      end else begin
         if (we_ctrl) begin
            ctrl_cs <= w_byte[`TMR_CTRL_CS_LSB +: 3];
            wave <= tmr_wave_t'(w_byte[`TMR_CTRL_WAVE_LSB +: 2]);
            act <= tmr_act_t'(w_byte[`TMR_CTRL_ACT_LSB +: 2]);
         end
         if (we_async) begin
            async_sel <= w_byte[`TMR_ASYNC_SEL_BIT];
            ext_sel <= w_byte[`TMR_ASYNC_EXT_BIT];
            ext_rise <= w_byte[`TMR_ASYNC_RISE_BIT];
         end
         if (we_mask) begin
            mask_ovf <= w_byte[`TMR_FLAG_OVF_BIT];
            mask_cmp <= w_byte[`TMR_FLAG_CMP_BIT];
         end
      end
   end

   // Counter, direction and match blocking
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= `TMR_BOTTOM;
         down <= 1'b0;
         block <= 1'b0;
      end else begin
         count <= next_count;
         down <= tif.tick ? next_down : down;
         block <= we_count ? 1'b1 : (tif.tick ? 1'b0 : block);
      end
   end

   // Compare registers; PWM writes land in the buffer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ocr_act <= `TMR_RST_BYTE;
         ocr_buf <= `TMR_RST_BYTE;
      end else begin
         ocr_buf <= we_cmp ? w_byte : ocr_buf;
         if (we_cmp && !pwm) begin
            ocr_act <= w_byte;
         end else if (buf_upd) begin
            ocr_act <= ocr_buf;
         end
      end
   end

   // Flags and output state; mode writes leave the output alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_ovf <= 1'b0;
         flag_cmp <= 1'b0;
         oc <= 1'b0;
      end else begin
         flag_ovf <= next_flag_ovf;
         flag_cmp <= next_flag_cmp;
         oc <= next_oc;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_cnt_write_prio: assert property (we_count |=> count == $past(w_byte))
      else $error("counter write lost");
   a_stop_holds: assert property (($past(ctrl_cs) == 3'h0 && !we_count) |=> $stable(count))
      else $error("counter moved while stopped");
   a_normal_wrap: assert property ((wave == TMR_WAVE_NORMAL && tick_run && at_max)
      |=> (count == 8'h00 && flag_ovf))
      else $error("normal wrap or overflow wrong");
   a_ctc_clear: assert property ((wave == TMR_WAVE_CTC && tick_run && match_eff) |=> count == 8'h00)
      else $error("CTC did not clear");
   a_match_flag: assert property (match_evt |=> flag_cmp)
      else $error("compare flag not set");
   a_block_match: assert property ((block && tif.tick && !flag_cmp) |=> !flag_cmp)
      else $error("blocked match set flag");
   a_force_noflag: assert property ((force_evt && !match_evt && !flag_cmp) |=> !flag_cmp)
      else $error("force set compare flag");
   a_buf_hold: assert property ((pwm && !buf_upd) |=> ocr_act == $past(ocr_act))
      else $error("active compare changed off boundary");
   a_action_zero: assert property ((act == TMR_ACT_NONE && !force_evt) |=> $stable(oc))
      else $error("output moved with no action");
   a_irq_gate: assert property ((flag_cmp && mask_cmp) |-> cmp_irq)
      else $error("compare irq missing");
   a_phase_turn: assert property ((wave == TMR_WAVE_PHASE && tick_run && at_max)
      |=> (down && count == 8'hfe))
      else $error("phase mode did not turn");

   c_ctc_match: cover property (wave == TMR_WAVE_CTC && match_evt);
   c_fast_ovf: cover property (wave == TMR_WAVE_FAST && ovf_evt);
   c_force: cover property (force_evt);
   c_phase_turn: cover property (wave == TMR_WAVE_PHASE && tick_run && at_max);
endmodule
`default_nettype wire

// [sim/tb_tmr_timer8.sv]
// Bench for the 8-bit timer: register access, counting, flags and compare output.
// Assumes the design files are compiled first; the crystal pin stays low.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"
module tb_tmr_timer8
   import tmr_pkg::*;
();
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic ovf_irq_ack = 0, cmp_irq_ack = 0;
   logic ext_pin = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic ovf_irq, cmp_irq, compare_output, compare_output_en;
   logic [31:0] d0, d1;
   logic [1:0] r0;
   int errors = 0;
   int tests_run = 0;

   tmr_timer8 #(.AW(5)) i_tmr_timer8 (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_count_pin(ext_pin),
      .crystal_pin_a(1'b0), .ovf_irq_ack(ovf_irq_ack), .cmp_irq_ack(cmp_irq_ack), .ovf_irq(ovf_irq),
      .cmp_irq(cmp_irq), .compare_output(compare_output), .compare_output_en(compare_output_en));

   // ----------------------------------------
   // Bus tasks and checking
   // ----------------------------------------
   task automatic chk(input logic c, input string m);
      tests_run++;
      if (c !== 1'b1) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask

   // Handshakes judged mid-cycle so the taking edge is known before it comes
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic aw_d, w_d, aw_t, w_t, b;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_d = 0;
      w_d = 0;
      while (!(aw_d && w_d)) begin
         @(negedge aclk);
         aw_t = s_axi_awready && !aw_d;
         w_t = s_axi_wready && !w_d;
         @(posedge aclk);
         if (aw_t) begin
            s_axi_awvalid <= 1'b0;
            aw_d = 1;
         end
         if (w_t) begin
            s_axi_wvalid <= 1'b0;
            w_d = 1;
         end
      end
      do begin
         @(negedge aclk);
         b = s_axi_bvalid;
         r0 = s_axi_bresp;
         @(posedge aclk);
      end while (b !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
      chk(r0 === 2'b00, "write response not OKAY");
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic v;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         v = s_axi_arready;
         @(posedge aclk);
      end while (v !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         v = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end while (v !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string m);
      rd(a, d0, r0);
      chk(d0 === e && r0 === 2'b00, m);
   endtask

   // Waits a fixed span measured in cycles, then realigns to a rising edge
   task automatic idle(input int n);
      repeat (n) @(negedge aclk);
      @(posedge aclk);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 6; i++) rchk(5'(4 * i), 32'h0000_0000, "register not zero after reset");
      rd(5'h18, d0, r0);
      chk(r0 === 2'b10 && d0 === 32'h0000_0000, "unmapped read not refused");
   endtask

   task automatic t_rw();
      wr(`TMR_OFS_COUNT, 32'h0000_00a5);
      rchk(`TMR_OFS_COUNT, 32'h0000_00a5, "count readback");
      wr(`TMR_OFS_COMPARE, 32'h0000_005a);
      rchk(`TMR_OFS_COMPARE, 32'h0000_005a, "compare readback");
   endtask

   // Force in normal mode toggles, clears; action zero and PWM force do nothing
   task automatic t_force();
      wr(`TMR_OFS_CTRL, 32'h0000_00a0);
      chk(compare_output === 1'b1 && compare_output_en === 1'b1, "force toggle");
      rchk(`TMR_OFS_FLAG, 32'h0000_0000, "force set a flag");
      wr(`TMR_OFS_CTRL, 32'h0000_0080);
      chk(compare_output === 1'b1 && compare_output_en === 1'b0, "action zero changed output");
      wr(`TMR_OFS_CTRL, 32'h0000_00b8);
      chk(compare_output === 1'b1, "mode change or PWM force changed output");
      wr(`TMR_OFS_CTRL, 32'h0000_00c0);
      chk(compare_output === 1'b0, "force clear");
      rchk(`TMR_OFS_CTRL, 32'h0000_0040, "force bit reads back");
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
   endtask

   task automatic t_ctc();
      wr(`TMR_OFS_COMPARE, 32'h0000_0003);
      wr(`TMR_OFS_COUNT, 32'h0000_0000);
      wr(`TMR_OFS_MASK, 32'h0000_0002);
      wr(`TMR_OFS_CTRL, 32'h0000_0011);
      idle(30);
      chk(cmp_irq === 1'b1, "no compare request");
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rd(`TMR_OFS_COUNT, d0, r0);
      rd(`TMR_OFS_COUNT, d1, r0);
      chk(d0 === d1 && d0 <= 32'h0000_0003, "counter ran past top or kept running");
      rchk(`TMR_OFS_FLAG, 32'h0000_0002, "flags in clear-on-match");
      cmp_irq_ack <= 1'b1;
      @(posedge aclk);
      cmp_irq_ack <= 1'b0;
      idle(1);
      chk(cmp_irq === 1'b0, "service did not clear compare flag");
   endtask

   task automatic t_ovf();
      wr(`TMR_OFS_MASK, 32'h0000_0000);
      wr(`TMR_OFS_COUNT, 32'h0000_00fe);
      wr(`TMR_OFS_CTRL, 32'h0000_0001);
      idle(20);
      chk(ovf_irq === 1'b0 && cmp_irq === 1'b0, "masked request raised");
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rchk(`TMR_OFS_FLAG, 32'h0000_0003, "wrap flags");
      wr(`TMR_OFS_MASK, 32'h0000_0001);
      chk(ovf_irq === 1'b1 && cmp_irq === 1'b0, "overflow mask");
      wr(`TMR_OFS_FLAG, 32'h0000_0003);
      rchk(`TMR_OFS_FLAG, 32'h0000_0000, "write one did not clear");
   endtask

   // Count written equal to compare while stopped: first tick must not match
   task automatic t_block();
      wr(`TMR_OFS_COMPARE, 32'h0000_0010);
      wr(`TMR_OFS_COUNT, 32'h0000_0010);
      wr(`TMR_OFS_CTRL, 32'h0000_0001);
      idle(8);
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rchk(`TMR_OFS_FLAG, 32'h0000_0000, "blocked match set flag");
      wr(`TMR_OFS_CTRL, 32'h0000_0018);
      wr(`TMR_OFS_COMPARE, 32'h0000_0040);
      rchk(`TMR_OFS_COMPARE, 32'h0000_0040, "buffered compare readback");
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rchk(`TMR_OFS_COMPARE, 32'h0000_0010, "active compare moved off top");
   endtask

   // Pin rising edges: three rises and two falls must give three counts
   task automatic t_ext();
      wr(`TMR_OFS_ASYNC, 32'h0000_0006);
      wr(`TMR_OFS_COUNT, 32'h0000_0000);
      wr(`TMR_OFS_CTRL, 32'h0000_0001);
      repeat (3) begin
         ext_pin <= 1'b0;
         idle(3);
         ext_pin <= 1'b1;
         idle(3);
      end
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rchk(`TMR_OFS_COUNT, 32'h0000_0003, "pin rising edges not counted");
      wr(`TMR_OFS_ASYNC, 32'h0000_0000);
   endtask

   // Phase mode from near max: turns down at max, no overflow there
   task automatic t_phase();
      wr(`TMR_OFS_COUNT, 32'h0000_00fd);
      wr(`TMR_OFS_CTRL, 32'h0000_0009);
      idle(6);
      wr(`TMR_OFS_CTRL, 32'h0000_0000);
      rd(`TMR_OFS_COUNT, d0, r0);
      chk(d0 > 32'h0000_00f0 && d0 < 32'h0000_00fd, "phase mode did not turn down");
      rchk(`TMR_OFS_FLAG, 32'h0000_0000, "overflow at max in phase mode");
   endtask

   task automatic finish_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Clock, then reset and the scenario sequence
   initial begin
      forever #2.5 aclk = ~aclk;
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_rw();
      t_force();
      t_ctc();
      t_ovf();
      t_block();
      t_ext();
      t_phase();
      finish_test();
   end

   // Hang guard well beyond the few hundred cycles the scenarios need
   initial begin
      #60000;
      errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      finish_test();
   end
endmodule
`default_nettype wire
